/* File: lic_gate.sv */
// execution-condition gating for interlock sections of the scan engine
`timescale 1ns/10ps
// Functional notes
// - condition at interlock_begin gates all instructions through next interlock_clear
// - gate on: instruction uses own condition, equal to ANDing with gate
// - gate off: timers inside section are reset
// - gate off: counters, shift registers, keep hold operands and values
// - gate off: all other instructions leave operands untouched
// - gate off: present OFF condition, resume after interlock_clear
// - nested interlock_begin gates from itself through the shared interlock_clear
// - repeated interlock_clear without begin has no extra effect
module lic_gate
    import lic_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic scan_start_i,
    input wire logic instr_valid_i,
    input wire logic [2:0] instr_op_i,
    input wire logic line_cond_i,
    output logic exec_cond_o,
    output logic timer_reset_o,
    output logic freeze_o,
    output logic ignore_o,
    output logic exec_valid_o,
    output logic in_section_o,
    output logic gate_o
);
    lic_step_if st ();

    logic gate_q, gate_d;
    logic active_q, active_d;
    logic exec_cond_q, timer_reset_q, freeze_q, ignore_q, exec_valid_q;

    wire lic_op_t op = lic_op_t'(instr_op_i);
    wire is_begin = instr_valid_i && (op == LIC_OP_BEGIN);
    wire is_clear = instr_valid_i && (op == LIC_OP_CLEAR);
    // an inner begin can only narrow: gate ANDs with the new condition
    wire begin_gate = active_q ? (gate_q && line_cond_i) : line_cond_i;
    // a word beside scan start is dropped, so it never counts as a body word
    wire body = instr_valid_i && !scan_start_i && !is_begin && !is_clear;

    assign st.gate = gate_q;
    assign st.op = op;

    lic_action_dec u_dec (
        .st(st)
    );

    always_comb begin
        gate_d = gate_q;
        active_d = active_q;
        if (scan_start_i) begin
            gate_d = LIC_GATE_RST;
            active_d = LIC_ACTIVE_RST;
        end else if (is_begin) begin
            gate_d = begin_gate;
            active_d = 1'b1;
        end else if (is_clear) begin
            // a second clear finds the gate open already: no extra effect
            gate_d = LIC_GATE_RST;
            active_d = LIC_ACTIVE_RST;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            gate_q <= LIC_GATE_RST;
        end else begin
            gate_q <= gate_d;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            active_q <= LIC_ACTIVE_RST;
        end else begin
            active_q <= active_d;
        end
    end

    // a dropped or marker word leaves every result low
    wire exec_cond_d = body && line_cond_i && gate_q;
    wire timer_reset_d = body && (st.action == LIC_ACT_RESET);
    wire freeze_d = body && (st.action == LIC_ACT_FREEZE);
    wire ignore_d = body && (st.action == LIC_ACT_IGNORE);

    // outputs registered; one cycle after the body instruction
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            exec_valid_q <= 1'b0;
            exec_cond_q <= 1'b0;
        end else begin
            exec_valid_q <= body;
            exec_cond_q <= exec_cond_d;
        end
    end

    // kept apart so each flop group stays short
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            timer_reset_q <= 1'b0;
            freeze_q <= 1'b0;
            ignore_q <= 1'b0;
        end else begin
            timer_reset_q <= timer_reset_d;
            freeze_q <= freeze_d;
            ignore_q <= ignore_d;
        end
    end

    assign exec_cond_o = exec_cond_q;
    assign timer_reset_o = timer_reset_q;
    assign freeze_o = freeze_q;
    assign ignore_o = ignore_q;
    assign exec_valid_o = exec_valid_q;
    assign in_section_o = active_q;
    assign gate_o = gate_q;

    chk_gate_and_cond: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (body && !scan_start_i) |=> (exec_cond_o == ($past(line_cond_i) && $past(gate_q))))
        else $error("exec condition not gated");
    chk_off_no_cond: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (body && !gate_q) |=> !exec_cond_o)
        else $error("condition passed while gate off");
    chk_timer_reset: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (body && !gate_q && op == LIC_OP_TIMER) |=> timer_reset_o && !freeze_o)
        else $error("timer not reset");
    chk_hold_freeze: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (body && !gate_q && op == LIC_OP_HOLD) |=> freeze_o && !timer_reset_o)
        else $error("holder not frozen");
    chk_other_ignore: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (body && !gate_q && op == LIC_OP_OTHER) |=> ignore_o && !exec_cond_o)
        else $error("other instruction not ignored");
    chk_begin_capture: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_begin && !scan_start_i && !active_q) |=> (gate_q == $past(line_cond_i)) && in_section_o)
        else $error("begin did not capture condition");
    chk_nested_narrow: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_begin && !scan_start_i && active_q && !gate_q) |=> !gate_q)
        else $error("inner begin reopened gate");
    chk_clear_open: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_clear && !scan_start_i) |=> gate_q && !in_section_o)
        else $error("clear did not open gate");
    chk_scan_start: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        scan_start_i |=> gate_q && !in_section_o && !exec_valid_o)
        else $error("scan start did not clear gate");

    // result pulses
    chk_body_valid: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        body
        |=> exec_valid_o)
        else $error("body word gave no result");
    chk_marker_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_begin || is_clear)
        |=> !exec_valid_o && !exec_cond_o)
        else $error("marker word gave a result");
    chk_scan_drop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        scan_start_i
        |=> !exec_cond_o && !timer_reset_o && !freeze_o && !ignore_o)
        else $error("word beside scan start not dropped");
    chk_idle_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !instr_valid_i
        |=> !exec_valid_o && !exec_cond_o && !timer_reset_o && !freeze_o && !ignore_o)
        else $error("result without a word");
    chk_on_no_action: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (body && gate_q)
        |=> !timer_reset_o && !freeze_o && !ignore_o)
        else $error("gate on but action forced");
    chk_on_timer_runs: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (body && gate_q && op == LIC_OP_TIMER)
        |=> exec_cond_o == $past(line_cond_i))
        else $error("timer lost own condition");
    chk_hold_on_cond: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (body && gate_q && op == LIC_OP_HOLD)
        |=> (exec_cond_o == $past(line_cond_i)) && !freeze_o)
        else $error("holder frozen while gate on");
    chk_one_action: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        exec_valid_o
        |-> $onehot0({timer_reset_o, freeze_o, ignore_o}))
        else $error("more than one action at once");
    chk_pulse_owner: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (exec_cond_o || timer_reset_o || freeze_o || ignore_o)
        |-> exec_valid_o)
        else $error("result pulse without valid");
    chk_off_valid: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (body && !gate_q)
        |=> exec_valid_o && (timer_reset_o || freeze_o || ignore_o))
        else $error("gate off word got no action");
    chk_high_ignore: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (body && !gate_q && instr_op_i > 3'h4)
        |=> ignore_o && !freeze_o && !timer_reset_o)
        else $error("spare code not ignored");
    chk_timer_no_cond: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        timer_reset_o
        |-> !exec_cond_o)
        else $error("timer reset with condition on");
    chk_freeze_no_cond: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        freeze_o
        |-> !exec_cond_o && !ignore_o)
        else $error("frozen word also ran");

    // gate and section state
    chk_gate_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!scan_start_i && !is_begin && !is_clear)
        |=> $stable(gate_q) && $stable(active_q))
        else $error("gate moved without a marker");
    chk_nested_and: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_begin && !scan_start_i && active_q && gate_q)
        |=> (gate_q == $past(line_cond_i)) && in_section_o)
        else $error("inner begin ignored its condition");
    chk_begin_enter: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_begin && !scan_start_i)
        |=> in_section_o)
        else $error("begin did not open a section");
    chk_repeat_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (is_clear && !scan_start_i && !active_q)
        |=> $stable(gate_q) && $stable(active_q))
        else $error("second clear changed state");
    chk_outside_open: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !active_q
        |-> gate_q)
        else $error("gate closed outside a section");
endmodule

/* File: lic_pkg.sv */
// package for the ladder interlock gating unit
package lic_pkg;
    localparam int LIC_OP_W = 3;
    typedef enum logic [2:0] {
        LIC_OP_OTHER = 3'h0,
        LIC_OP_BEGIN = 3'h1,
        LIC_OP_CLEAR = 3'h2,
        LIC_OP_TIMER = 3'h3,
        LIC_OP_HOLD = 3'h4
    } lic_op_t;
    localparam logic LIC_GATE_RST = 1'b1;
    localparam logic LIC_ACTIVE_RST = 1'b0;
    localparam logic [1:0] LIC_ACT_RUN = 2'h0;
    localparam logic [1:0] LIC_ACT_RESET = 2'h1;
    localparam logic [1:0] LIC_ACT_FREEZE = 2'h2;
    localparam logic [1:0] LIC_ACT_IGNORE = 2'h3;
endpackage

/* File: lic_step_if.sv */
// interface carrying one classified instruction step to the decision unit
`timescale 1ns/10ps
interface lic_step_if;
    import lic_pkg::*;
    logic gate;
    lic_op_t op;
    logic [1:0] action;
    modport core (output gate, output op, input action);
    modport dec (input gate, input op, output action);
endinterface

/* File: lic_action_dec.sv */
// decides how a gated instruction behaves
`timescale 1ns/10ps
module lic_action_dec
    import lic_pkg::*;
(
    lic_step_if.dec st
);
    wire gate_off = !st.gate;
    wire is_timer = (st.op == LIC_OP_TIMER);
    wire is_hold = (st.op == LIC_OP_HOLD);
    // timers reset, holders frozen, rest ignored when gate off
    assign st.action = !gate_off ? LIC_ACT_RUN :
                       is_timer ? LIC_ACT_RESET :
                       is_hold ? LIC_ACT_FREEZE :
                       LIC_ACT_IGNORE;
endmodule

/* File: lic_seq_model.sv */
// instruction sequencer model feeding the gating unit
`timescale 1ns/10ps
module lic_seq_model (
    input wire logic clk_sys_i,
    output logic scan_start_o,
    output logic instr_valid_o,
    output logic [2:0] instr_op_o,
    output logic line_cond_o
);
    initial begin
        {scan_start_o, instr_valid_o, instr_op_o, line_cond_o} = 6'h00;
    end
    // one word per cycle, never a step instruction
    task automatic drive(input logic s, input logic v, input logic [2:0] o, input logic c);
        @(posedge clk_sys_i);
        #1;
        scan_start_o = s;
        instr_valid_o = v;
        instr_op_o = o;
        line_cond_o = (v && o == 3'h2) ? 1'b0 : c;
    endtask
endmodule

/* File: lic_gate_bench.sv */
// self-checking bench for the interlock gating unit
`timescale 1ns/10ps
module lic_gate_bench;
    import lic_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic ss, iv, lc;
    logic [2:0] op;
    wire [6:0] seen;
    logic [6:0] exp_q = 7'h01;
    int num_errors = 0, check_count = 0, cycles = 0, gate = 1, insec = 0;
    integer seed = 32'hd262e0c1;
    lic_seq_model u_seq (.clk_sys_i(clk_sys_i), .scan_start_o(ss), .instr_valid_o(iv), .instr_op_o(op),
        .line_cond_o(lc));
    lic_gate u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scan_start_i(ss), .instr_valid_i(iv), .instr_op_i(op),
        .line_cond_i(lc), .exec_cond_o(seen[6]), .timer_reset_o(seen[5]), .freeze_o(seen[4]),
        .ignore_o(seen[3]), .exec_valid_o(seen[2]), .in_section_o(seen[1]), .gate_o(seen[0]));
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [6:0] s, input logic [6:0] e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t: outputs %b expected %b", $time, s, e);
        end
    endtask
    function automatic logic rb();
        return 1'($random(seed));
    endfunction
    // body ops only; begin and clear are placed on purpose
    function automatic logic [2:0] rop();
        logic [2:0] o;
        o = 3'($random(seed));
        return (o == 3'h1 || o == 3'h2) ? 3'h3 : o;
    endfunction
    task automatic step(input logic s, input logic v, input logic [2:0] o, input logic c);
        int b;
        u_seq.drive(s, v, o, c);
        check(seen, exp_q);
        b = v && !s && o != 3'h1 && o != 3'h2;
        if (s || (v && o == 3'h2)) begin
            gate = 1;
            insec = 0;
        end else if (v && o == 3'h1) begin
            gate = insec ? gate & c : c;
            insec = 1;
        end
        exp_q = {b && gate && c, b && !gate && o == 3'h3, b && !gate && o == 3'h4,
            b && !gate && o != 3'h3 && o != 3'h4, b == 1, insec == 1, gate == 1};
    endtask
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        #1 rst_i = 1'b0;
        for (int n = 0; n < 40; n++) begin
            step(1'b1, 1'b1, (n % 2) ? 3'h1 : rop(), (n % 2) ? 1'b0 : 1'b1); // dropped beside scan start
            repeat (1 + n % 3) begin
                step(1'b0, 1'b1, 3'h1, rb());
                repeat (4) step(1'b0, rb(), rop(), rb());
            end
            step(1'b0, 1'b1, 3'h2, 1'b0); // every section closed
            if (n % 2) step(1'b0, 1'b1, 3'h2, 1'b0);
            repeat (3) step(1'b0, rb(), rop(), rb());
            $display("test scan %0d done", n);
        end
        step(1'b0, 1'b1, 3'h1, 1'b0);
        step(1'b0, 1'b0, 3'h0, 1'b0);
        rst_i = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1 check(seen, 7'h01);
        rst_i = 1'b0;
        {gate, insec, exp_q} = {32'sd1, 32'sd0, 7'h01};
        step(1'b0, 1'b1, 3'h3, 1'b1);
        step(1'b0, 1'b0, 3'h0, 1'b0);
        $display("test reset done");
        report_and_stop();
    end
endmodule
